/* File: core/halt_wdt_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef HALT_WDT_CONSTS_SVH
`define HALT_WDT_CONSTS_SVH
`define OFF_WDT_CTRL 8'h00
`define OFF_RST_FLAGS 8'h04
`define OFF_CLK_CTRL 8'h08
`define OFF_PA_WAKE 8'h0C
`define OFF_PWR_STAT 8'h10
`define WDT_CTRL_RESET 8'h53
`define KEY_DISABLE 5'h15
`define KEY_ENABLE 5'h0A
`define KEY_LSB 3
`define PERIOD_LSB 0
`define FLAG_KEY_RST 0
`define PD_FLAG_BIT 0
`define TO_FLAG_BIT 1
`define SRESET_DELAY_NS 1000
`define CLK_PERIOD_NS 8
`define SRESET_CYCLES ((`SRESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_CNT_W 19
`endif

/* File: core/halt_wdt_pkg.sv */
// types shared by the power-down controller, its checker and the bench
package halt_wdt_pkg;
	typedef enum logic [2:0] {MODE_RUN, MODE_SLEEP, MODE_IDLE_SUB, MODE_IDLE_BOTH,
		MODE_IDLE_FAST} pwr_mode_t;
	typedef struct packed {
		logic hs_clk_en;
		logic sub_clk_en;
		logic cpu_run;
	} clk_gate_t;
	typedef struct packed {
		logic pc_sp_reset;
		logic full_reset;
		logic resume_next;
		logic irq_respond;
	} wake_act_t;
endpackage

/* File: core/wdt_counter.sv */
// watchdog counter clocked by the sampled low-speed rc clock
`timescale 1ns/100ps
`include "halt_wdt_consts.svh"
module wdt_counter #(
	parameter int CNT_W = `WDT_CNT_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic low_speed_rc_osc_tick,
	input wire logic enable,
	input wire logic clear,
	input wire logic [2:0] period,
	output logic overflow
);
	logic [CNT_W-1:0] cnt_ff;

	// R16: period code to terminal
	function automatic logic [CNT_W-1:0] terminal(input logic [2:0] code);
		logic [4:0] sh;
		sh = 5'h00;
		unique case (code)
			3'h0: sh = 5'h08;
			3'h1: sh = 5'h0A;
			3'h2: sh = 5'h0C;
			3'h3: sh = 5'h0E;
			3'h4: sh = 5'h0F;
			3'h5: sh = 5'h10;
			3'h6: sh = 5'h11;
			3'h7: sh = 5'h12;
		endcase
		return CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << sh) - 1'b1);
	endfunction

	// R24: single overflow pulse
	// at or past terminal, so a shorter period written mid-count cannot wrap the counter
	assign overflow = enable && low_speed_rc_osc_tick && !clear && (cnt_ff >= terminal(period));

	// R06: cleared, then counts only if enabled
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= '0;
		end else if (ce) begin
			if (clear || !enable || overflow) begin
				cnt_ff <= '0;
			end else if (low_speed_rc_osc_tick) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end
endmodule // wdt_counter

/* File: core/halt_wdt_ctrl.sv */
// halt mode controller, wake-up logic and watchdog register file over axi4-lite
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "halt_wdt_consts.svh"
// What this block does
// R01: halt with hs keep 0, sub keep 1 enters sub-only idle
// R02: halt with both keep bits 1 enters both-clocks idle
// R03: halt with hs keep 1, sub keep 0 enters fast-only idle
// R04: idle entry leaves memory, registers and ports untouched
// R05: halt sets power-down flag and clears timeout flag
// R06: halt clears watchdog counter; counts on only if enabled
// R07: wake on reset pin, port a fall, interrupt or watchdog overflow
// R08: pin wake gives full reset; watchdog wake gives watchdog reset
// R09: timeout in halt sets timeout flag and resets pc and sp only
// R10: power-down flag cleared by power-up or clear-watchdog, set by halt
// R11: enabled port a pin falling edge wakes; resume after halt
// R12: disabled interrupt or full stack wakes and resumes; stays pending
// R13: enabled interrupt with free stack gets normal response
// R14: interrupt already pending before halt is no wake source
// R15: watchdog counter clocked by low-speed rc oscillator
// R16: period field selects 2^8..2^18 rc periods
// R17: key 10101 disables, 01010 enables, else device reset
// R18: bad key resets after delay and sets key reset flag
// R19: hardware only sets key reset flag; software clears it
// R20: upper four reset flag bits read zero
// R21: halt with both keep bits 0 enters sleep; only watchdog runs
// R22: timeout while running resets device and sets timeout flag
// R23: clear-watchdog instruction is the only software counter clear
// R24: terminal count gives one overflow, routed to reset or wake
module halt_wdt_ctrl #(
	parameter int PA_W = 8,
	parameter int SRESET_CYC = `SRESET_CYCLES
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic HALT_EXEC,
	input wire logic CLEAR_WATCHDOG_INSTRUCTION_EXEC,
	input wire logic [PA_W-1:0] PORT_A_IN,
	input wire logic EXT_RESET_N,
	input wire logic LOW_SPEED_RC_OSC_CLK,
	input wire logic IRQ_REQ,
	input wire logic IRQ_ENABLED,
	input wire logic STACK_FULL,
	output halt_wdt_pkg::clk_gate_t CLK_GATE,
	output halt_wdt_pkg::wake_act_t WAKE_ACT,
	output logic DEVICE_RESET,
	output logic [2:0] PWR_MODE,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	////////////////////////////////////////////////////////////////////////////////
	// registers and synchronisers
	logic [7:0] wdt_ctrl_ff, aw_addr_ff;
	logic [1:0] clk_ctrl_ff, bresp_ff, rresp_ff;
	logic [PA_W-1:0] pa_wake_ff;
	logic key_rst_flag_ff, pd_flag_ff, to_flag_ff, irq_pending_at_halt_ff;
	halt_wdt_pkg::pwr_mode_t mode_ff, nxt_mode;
	logic [PA_W-1:0] pa_s1_ff, pa_s2_ff, pa_s3_ff;
	logic [2:0] rst_s_ff, low_speed_rc_osc_s_ff;
	logic irq_s1_ff, irq_s2_ff;
	logic [15:0] sreset_cnt_ff;
	logic sreset_busy_ff, dev_reset_ff;
	halt_wdt_pkg::wake_act_t wake_ff;
	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
	logic [31:0] w_data_ff, rdata_ff;
	logic [3:0] w_strb_ff;

	logic [4:0] key;
	logic wdt_en, key_bad, low_speed_rc_osc_tick, wdt_ovf, in_halt;
	logic halt_go, pa_wake, pin_wake, irq_wake, wr_fire;

	assign key = wdt_ctrl_ff[`KEY_LSB +: 5];
	// R17: key decode
	assign wdt_en = (key == `KEY_ENABLE);
	assign key_bad = (key != `KEY_ENABLE) && (key != `KEY_DISABLE);
	assign in_halt = (mode_ff != halt_wdt_pkg::MODE_RUN);
	assign halt_go = HALT_EXEC && !in_halt;

	// pins and the rc clock cross into CLK through two flops
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pa_s1_ff <= '1;
			pa_s2_ff <= '1;
			pa_s3_ff <= '1;
			rst_s_ff <= 3'h7;
			low_speed_rc_osc_s_ff <= 3'h0;
			irq_s1_ff <= 1'b0;
			irq_s2_ff <= 1'b0;
		end else if (CE) begin
			pa_s1_ff <= PORT_A_IN;
			pa_s2_ff <= pa_s1_ff;
			pa_s3_ff <= pa_s2_ff;
			rst_s_ff <= {rst_s_ff[1:0], EXT_RESET_N};
			low_speed_rc_osc_s_ff <= {low_speed_rc_osc_s_ff[1:0], LOW_SPEED_RC_OSC_CLK};
			irq_s1_ff <= IRQ_REQ;
			irq_s2_ff <= irq_s1_ff;
		end
	end
	// R15: rising edge of rc clock steps the watchdog
	assign low_speed_rc_osc_tick = low_speed_rc_osc_s_ff[1] && !low_speed_rc_osc_s_ff[2];

	// R11: enabled falling edge only
	assign pa_wake = |(pa_wake_ff & pa_s3_ff & ~pa_s2_ff);
	assign pin_wake = rst_s_ff[2] && !rst_s_ff[1];
	// R14: interrupt pending at halt entry cannot wake
	assign irq_wake = irq_s2_ff && !irq_pending_at_halt_ff;
	////////////////////////////////////////////////////////////////////////////////
	// watchdog counter
	// R23: halt, clear instruction or a bad key drive the clear input; disable and overflow also zero it
	wdt_counter #(.CNT_W(`WDT_CNT_W)) u_wdt (
		.clk(CLK),
		.srst(SRST),
		.ce(CE),
		.low_speed_rc_osc_tick(low_speed_rc_osc_tick),
		.enable(wdt_en),
		.clear(halt_go || CLEAR_WATCHDOG_INSTRUCTION_EXEC || key_bad),
		.period(wdt_ctrl_ff[`PERIOD_LSB +: 3]),
		.overflow(wdt_ovf)
	);
	////////////////////////////////////////////////////////////////////////////////
	// mode machine
	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			halt_wdt_pkg::MODE_RUN: begin
				if (HALT_EXEC) begin
					unique case (clk_ctrl_ff)
						// R21: sleep
						2'b00: nxt_mode = halt_wdt_pkg::MODE_SLEEP;
						// R01: sub-only idle
						2'b01: nxt_mode = halt_wdt_pkg::MODE_IDLE_SUB;
						// R03: fast-only idle
						2'b10: nxt_mode = halt_wdt_pkg::MODE_IDLE_FAST;
						// R02: both clocks idle
						2'b11: nxt_mode = halt_wdt_pkg::MODE_IDLE_BOTH;
					endcase
				end
			end
			halt_wdt_pkg::MODE_SLEEP, halt_wdt_pkg::MODE_IDLE_SUB,
			halt_wdt_pkg::MODE_IDLE_BOTH, halt_wdt_pkg::MODE_IDLE_FAST: begin
				// R07: four wake sources
				if (pin_wake || pa_wake || irq_wake || wdt_ovf) begin
					nxt_mode = halt_wdt_pkg::MODE_RUN;
				end
			end
			default: nxt_mode = halt_wdt_pkg::MODE_RUN;
		endcase
	end

	// R04: only clock gates change; no state beyond this block is touched
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mode_ff <= halt_wdt_pkg::MODE_RUN;
		end else if (CE) begin
			mode_ff <= nxt_mode;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			irq_pending_at_halt_ff <= 1'b0;
		end else if (CE) begin
			if (halt_go) begin
				irq_pending_at_halt_ff <= irq_s2_ff;
			end else if (!irq_s2_ff) begin
				irq_pending_at_halt_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			CLK_GATE <= '{hs_clk_en: 1'b1, sub_clk_en: 1'b1, cpu_run: 1'b1};
		end else if (CE) begin
			CLK_GATE.cpu_run <= (nxt_mode == halt_wdt_pkg::MODE_RUN);
			CLK_GATE.hs_clk_en <= (nxt_mode == halt_wdt_pkg::MODE_RUN) ||
				(nxt_mode == halt_wdt_pkg::MODE_IDLE_BOTH) ||
				(nxt_mode == halt_wdt_pkg::MODE_IDLE_FAST);
			CLK_GATE.sub_clk_en <= (nxt_mode == halt_wdt_pkg::MODE_RUN) ||
				(nxt_mode == halt_wdt_pkg::MODE_IDLE_BOTH) ||
				(nxt_mode == halt_wdt_pkg::MODE_IDLE_SUB);
		end
	end
	assign PWR_MODE = mode_ff;
	////////////////////////////////////////////////////////////////////////////////
	// wake actions and reset outputs, one-cycle pulses
	always_ff @(posedge CLK) begin
		if (SRST) begin
			wake_ff <= '0;
		end else if (CE) begin
			wake_ff <= '0;
			if (in_halt) begin
				if (pin_wake) begin
					// R08: pin gives full reset
					wake_ff.full_reset <= 1'b1;
				end else if (wdt_ovf) begin
					// R09: pc and sp only
					wake_ff.pc_sp_reset <= 1'b1;
				end else if (irq_wake && IRQ_ENABLED && !STACK_FULL) begin
					// R13: normal response
					wake_ff.irq_respond <= 1'b1;
				end else if (pa_wake || irq_wake) begin
					// R12: resume after halt, request left pending
					wake_ff.resume_next <= 1'b1;
				end
			end
		end
	end
	assign WAKE_ACT = wake_ff;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			sreset_busy_ff <= 1'b0;
			sreset_cnt_ff <= '0;
			dev_reset_ff <= 1'b0;
		end else if (CE) begin
			dev_reset_ff <= 1'b0;
			// R22: running timeout resets device
			if (wdt_ovf && !in_halt) begin
				dev_reset_ff <= 1'b1;
			end
			// R18: bad key resets after the delay
			if (key_bad && !sreset_busy_ff) begin
				sreset_busy_ff <= 1'b1;
				sreset_cnt_ff <= 16'(SRESET_CYC - 1);
			end else if (sreset_busy_ff) begin
				if (sreset_cnt_ff == 16'h0000) begin
					dev_reset_ff <= 1'b1;
					sreset_busy_ff <= 1'b0;
				end else begin
					sreset_cnt_ff <= sreset_cnt_ff - 16'h0001;
				end
			end
		end
	end
	assign DEVICE_RESET = dev_reset_ff;
	////////////////////////////////////////////////////////////////////////////////
	// status flags
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pd_flag_ff <= 1'b0;
			to_flag_ff <= 1'b0;
		end else if (CE) begin
			// R10: halt sets, clear instruction clears
			if (halt_go) begin
				pd_flag_ff <= 1'b1;
			end else if (CLEAR_WATCHDOG_INSTRUCTION_EXEC) begin
				pd_flag_ff <= 1'b0;
			end
			// R05: halt clears timeout; timeout sets it and wins
			if (wdt_ovf) begin
				to_flag_ff <= 1'b1;
			end else if (halt_go || CLEAR_WATCHDOG_INSTRUCTION_EXEC) begin
				to_flag_ff <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	assign S_AXI_AWREADY = CE && !aw_got_ff && !bvalid_ff;
	assign S_AXI_WREADY = CE && !w_got_ff && !bvalid_ff;
	assign S_AXI_ARREADY = CE && !rvalid_ff;
	assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
		end else if (CE) begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_ff <= 1'b1;
				w_data_ff <= S_AXI_WDATA;
				w_strb_ff <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= (aw_addr_ff > `OFF_PWR_STAT || aw_addr_ff[1:0] != 2'h0) ?
					2'h2 : 2'h0;
			end else if (bvalid_ff && S_AXI_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP = bresp_ff;
	// writable registers; only byte lane 0 carries data
	always_ff @(posedge CLK) begin
		if (SRST) begin
			wdt_ctrl_ff <= `WDT_CTRL_RESET;
			clk_ctrl_ff <= 2'h0;
			pa_wake_ff <= '0;
			key_rst_flag_ff <= 1'b0;
		end else if (CE) begin
			if (wr_fire && w_strb_ff[0]) begin
				unique case (aw_addr_ff)
					`OFF_WDT_CTRL: wdt_ctrl_ff <= w_data_ff[7:0];
					`OFF_CLK_CTRL: clk_ctrl_ff <= w_data_ff[1:0];
					`OFF_PA_WAKE: pa_wake_ff <= w_data_ff[PA_W-1:0];
					default: ;
				endcase
			end
			// R19: hardware sets, software write of 0 clears, set wins
			if (key_bad) begin
				key_rst_flag_ff <= 1'b1;
			end else if (wr_fire && w_strb_ff[0] && aw_addr_ff == `OFF_RST_FLAGS &&
				!w_data_ff[`FLAG_KEY_RST]) begin
				key_rst_flag_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'h0;
		end else if (CE) begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= 2'h0;
				rdata_ff <= 32'h00000000;
				unique case (S_AXI_ARADDR)
					`OFF_WDT_CTRL: rdata_ff[7:0] <= wdt_ctrl_ff;
					// R20: upper bits read zero
					`OFF_RST_FLAGS: rdata_ff[`FLAG_KEY_RST] <= key_rst_flag_ff;
					`OFF_CLK_CTRL: rdata_ff[1:0] <= clk_ctrl_ff;
					`OFF_PA_WAKE: rdata_ff[PA_W-1:0] <= pa_wake_ff;
					`OFF_PWR_STAT: begin
						rdata_ff[`PD_FLAG_BIT] <= pd_flag_ff;
						rdata_ff[`TO_FLAG_BIT] <= to_flag_ff;
					end
					default: rresp_ff <= 2'h2;
				endcase
			end else if (rvalid_ff && S_AXI_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end
	end
	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RDATA = rdata_ff;
	assign S_AXI_RRESP = rresp_ff;
endmodule // halt_wdt_ctrl

/* File: verif/halt_wdt_chk.sv */
// port assertions for the halt and watchdog controller
`timescale 1ns/100ps
module halt_wdt_chk (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic HALT_EXEC,
	input wire logic EXT_RESET_N,
	input wire halt_wdt_pkg::clk_gate_t CLK_GATE,
	input wire halt_wdt_pkg::wake_act_t WAKE_ACT,
	input wire logic DEVICE_RESET,
	input wire logic [2:0] PWR_MODE,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID
);
	logic [7:0] ra_ff;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	////////////////////////////////////////////////////////////////
	// the read word is judged against the address that asked for it
	always_ff @(posedge CLK) begin
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			ra_ff <= S_AXI_ARADDR;
		end
	end
	////////////////////////////////////////////////////////////////
	AST_SLEEP_GATES: assert property (PWR_MODE == 3'h1 |-> CLK_GATE == 3'h0)
		else $error("sleep with a clock on");
	AST_SUB_GATES: assert property (PWR_MODE == 3'h2 |-> CLK_GATE == 3'h2)
		else $error("sub idle gates wrong");
	AST_BOTH_GATES: assert property (PWR_MODE == 3'h3 |-> CLK_GATE == 3'h6)
		else $error("both idle gates wrong");
	AST_FAST_GATES: assert property (PWR_MODE == 3'h4 |-> CLK_GATE == 3'h4)
		else $error("fast idle gates wrong");
	AST_HALT_ENTER: assert property (CE && HALT_EXEC && PWR_MODE == 3'h0 |=>
		PWR_MODE != 3'h0 && !CLK_GATE.cpu_run)
		else $error("halt not entered");
	AST_PIN_WAKE: assert property (PWR_MODE != 3'h0 && $fell(EXT_RESET_N) |->
		##[1:6] WAKE_ACT.full_reset)
		else $error("pin wake missing");
	AST_RST_ONE: assert property ($rose(DEVICE_RESET) |=> !DEVICE_RESET)
		else $error("reset pulse too long");
	AST_HALT_WDT: assert property (WAKE_ACT.pc_sp_reset |-> !DEVICE_RESET && PWR_MODE == 3'h0)
		else $error("halted timeout reset all");
	AST_ONE_WAKE: assert property ($onehot0(WAKE_ACT))
		else $error("two wake actions");
	AST_FLAGS_HI: assert property (S_AXI_RVALID && ra_ff == 8'h04 |->
		S_AXI_RDATA[31:4] == 28'h0)
		else $error("flag upper bits set");
endmodule // halt_wdt_chk

bind halt_wdt_ctrl halt_wdt_chk chk (.CLK(CLK), .SRST(SRST), .CE(CE),
	.HALT_EXEC(HALT_EXEC), .EXT_RESET_N(EXT_RESET_N), .CLK_GATE(CLK_GATE),
	.WAKE_ACT(WAKE_ACT), .DEVICE_RESET(DEVICE_RESET), .PWR_MODE(PWR_MODE),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID));

/* File: verif/cpu_model.sv */
// cpu core stand-in turning bench requests into instruction pulses
`timescale 1ns/100ps
module cpu_model (
	input wire logic clk,
	input wire logic do_halt,
	input wire logic do_clr,
	output logic halt_exec,
	output logic clr_exec
);
	logic h_ff;
	logic c_ff;
	// halt issue
	// one pulse per request, as one executed instruction
	always_ff @(posedge clk) begin
		h_ff <= do_halt;
		halt_exec <= do_halt && !h_ff;
	end
	always_ff @(posedge clk) begin
		c_ff <= do_clr;
		clr_exec <= do_clr && !c_ff;
	end
endmodule // cpu_model

/* File: verif/testbench.sv */
// self-checking bench for the halt and watchdog controller
`timescale 1ns/100ps
module testbench;
	logic clk, low_speed_rc_osc, hx, cx, dr, awr, wrd, bv, arr, rv;
	logic srst = 1'b1, ern = 1'b1, hreq = 1'b0, creq = 1'b0, irq = 1'b0;
	logic ien = 1'b0, sfull = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
	logic arv = 1'b0, rrdy = 1'b0;
	logic [7:0] pa = 8'hFF, awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, d;
	logic [1:0] br, rr, rsp;
	logic [2:0] mode;
	logic [3:0] ws;
	halt_wdt_pkg::clk_gate_t gate;
	halt_wdt_pkg::wake_act_t wact;
	logic [2:0] mt [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
	int err_total = 0, num_checks = 0, n;
	halt_wdt_ctrl #(.SRESET_CYC(4)) DUT (.CLK(clk), .SRST(srst), .CE(1'b1),
		.HALT_EXEC(hx), .CLEAR_WATCHDOG_INSTRUCTION_EXEC(cx), .PORT_A_IN(pa), .EXT_RESET_N(ern),
		.LOW_SPEED_RC_OSC_CLK(low_speed_rc_osc), .IRQ_REQ(irq), .IRQ_ENABLED(ien), .STACK_FULL(sfull),
		.CLK_GATE(gate), .WAKE_ACT(wact), .DEVICE_RESET(dr), .PWR_MODE(mode),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy));
	cpu_model cpu (.clk(clk), .do_halt(hreq), .do_clr(creq), .halt_exec(hx),
		.clr_exec(cx));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// rc clock of ten core cycles, offset so it never lines up
	initial begin
		low_speed_rc_osc = 1'b0;
		#3;
		forever #40 low_speed_rc_osc = ~low_speed_rc_osc;
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bus tasks sample at the falling edge, act after the rising one
	task wr(input logic [7:0] a, input logic [7:0] v);
		logic ta, tw, b;
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wrd;
			b = bv;
			rsp = br;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
		end
		// bready stays up; lowering it here would clash with the next call's raise
	endtask
	task rd(input logic [7:0] a);
		logic t, v;
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge clk);
			t = arv && arr;
			v = rv;
			d = rdat;
			rsp = rr;
			@(posedge clk);
			if (t)
				arv <= 1'b0;
		end
		// rready stays up for the same reason
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask
	task clr;
		creq <= 1'b1;
		@(posedge clk);
		creq <= 1'b0;
		@(posedge clk);
	endtask
	// waits for a reset pulse (s=1) or a wake action (s=0), bounded
	task wt(input logic s, input int m);
		n = 0;
		ws = 4'h0;
		do begin
			@(negedge clk);
			n++;
			ws = wact;
		end while ((s ? dr : |wact) !== 1'b1 && n < m);
		@(posedge clk);
	endtask
	task halt(input int k);
		wr(8'h08, k[7:0]);
		hreq <= 1'b1;
		@(posedge clk);
		hreq <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(mode, mt[k]);
		chk(gate, {k[1], k[0], 1'b0});
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		rdc(8'h00, 32'h53);
		rdc(8'h04, 32'h00);
		rdc(8'h14, 32'h00);
		chk(rsp, 2'b10);
		wr(8'h14, 8'h5A);
		chk(rsp, 2'b10);
		$display("test regs done");
	endtask
	task t_modes;
		wr(8'h0C, 8'h01);
		for (int k = 0; k < 4; k++) begin
			halt(k);
			rdc(8'h10, 32'h01);
			pa <= 8'hFD;
			wt(1'b0, 20);
			chk(ws, 4'h0);
			pa <= 8'hFC;
			wt(1'b0, 20);
			chk(ws, 4'h2);
			pa <= 8'hFF;
			rdc(8'h08, k);
			clr;
			rdc(8'h10, 32'h00);
		end
		$display("test modes done");
	endtask
	task t_irq;
		ien <= 1'b1;
		halt(3);
		irq <= 1'b1;
		wt(1'b0, 20);
		chk(ws, 4'h1);
		irq <= 1'b0;
		sfull <= 1'b1;
		halt(2);
		irq <= 1'b1;
		wt(1'b0, 20);
		chk(ws, 4'h2);
		halt(1);
		wt(1'b0, 20);
		chk(ws, 4'h0);
		irq <= 1'b0;
		ern <= 1'b0;
		wt(1'b0, 20);
		chk(ws, 4'h4);
		ern <= 1'b1;
		sfull <= 1'b0;
		$display("test irq done");
	endtask
	task t_wdt;
		wr(8'h00, 8'h50);
		clr;
		wt(1'b1, 4000);
		chk(n >= 2540 && n <= 2580, 1);
		rdc(8'h10, 32'h02);
		wr(8'h00, 8'h50);
		halt(0);
		wt(1'b0, 4000);
		chk(ws, 4'h8);
		rdc(8'h10, 32'h03);
		$display("test watchdog done");
	endtask
	task t_key;
		wr(8'h00, 8'h03);
		wt(1'b1, 40);
		chk(n >= 1 && n <= 6, 1);
		wr(8'h00, 8'h53);
		rdc(8'h04, 32'h01);
		wr(8'h04, 8'h01);
		rdc(8'h04, 32'h01);
		wr(8'h04, 8'h00);
		chk(rsp, 2'b00);
		rdc(8'h04, 32'h00);
		wr(8'h00, 8'hA8);
		clr;
		wt(1'b1, 3000);
		chk(n, 3000);
		$display("test key done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_modes;
		t_irq;
		t_wdt;
		t_key;
		stop_test;
	end
endmodule // testbench
